/* hw/qec_filter.sv */
// Two-flop synchroniser and stability filter for one encoder input
`timescale 1ns/100ps
module qec_filter
    import qec_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              rstn,
    input  wire logic              pin,
    input  wire logic              long_sel,
    output logic                   level
);
    typedef struct packed {
        logic              s1;
        logic              s2;
        logic              lvl;
        logic [FILT_W-1:0] cnt;
    } qec_filt_state_type;

    qec_filt_state_type st_ff, nxt_st;

    always_comb begin
        logic [FILT_W-1:0] limit;
        limit        = long_sel ? LONG_CNT : SHORT_CNT;  // [RULE9] [RULE10]
        nxt_st       = st_ff;
        nxt_st.s1    = pin;
        nxt_st.s2    = st_ff.s1;
        // Change accepted only after it holds for the full window
        if (st_ff.s2 == st_ff.lvl) begin
            nxt_st.cnt = '0;
        end else if (st_ff.cnt >= limit) begin
            nxt_st.lvl = st_ff.s2;
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + FILT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin  // [RULE11]
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.lvl;

    a_short_pulse_drop: assert property (@(posedge clock) disable iff (!rstn)  // [RULE10]
        !long_sel && (st_ff.s2 != st_ff.lvl) && $past(st_ff.s2 == st_ff.lvl) ##1
        !long_sel && (st_ff.s2 != st_ff.lvl) ##1
        (st_ff.s2 == st_ff.lvl) |-> st_ff.lvl == $past(st_ff.lvl, 2))
        else $error("filter accepted a change that did not persist");
    a_long_window: assert property (@(posedge clock) disable iff (!rstn)  // [RULE9]
        long_sel && $changed(st_ff.lvl) |->
        $past(st_ff.s2 != st_ff.lvl, 1) && $past(st_ff.s2 != st_ff.lvl, LONG_FILT))
        else $error("long filter accepted change too early");
endmodule

/* hw/qec_pkg.sv */
// Package for the quadrature encoder counter: register map, fields, timing
package qec_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SAMPLE_HZ       = 50_000_000;
    localparam int unsigned LONG_FILT       = 15;
    localparam int unsigned SHORT_FILT      = 3;
    localparam int unsigned FILT_W          = 4;
    localparam logic [FILT_W-1:0] LONG_CNT  = FILT_W'(LONG_FILT - 1);
    localparam logic [FILT_W-1:0] SHORT_CNT = FILT_W'(SHORT_FILT - 1);

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_COUNT  = 8'h04;
    localparam logic [7:0] ADDR_RAW    = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQST  = 8'h10;
    localparam logic [7:0] ADDR_IRQMSK = 8'h14;

    // Control bit positions
    localparam int unsigned CB_MODE     = 0;
    localparam int unsigned CB_FILT     = 1;
    localparam int unsigned CB_IDXRISE  = 2;
    localparam int unsigned CB_GATE_EN  = 3;
    localparam int unsigned CB_GATE_INV = 4;
    localparam int unsigned CB_ARM      = 5;
    localparam int unsigned CB_ZERO     = 6;
    localparam int unsigned CTRL_W      = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h02;

    // Interrupt bits: index captured, count moved
    localparam int unsigned IB_INDEX = 0;
    localparam int unsigned IB_MOVE  = 1;
    localparam int unsigned IRQ_W    = 2;

    typedef struct packed {
        logic a;
        logic b;
        logic idx;
        logic gate;
    } qec_enc_type;

    typedef struct packed {
        logic [31:0]       count;
        logic [31:0]       raw;
        logic [CTRL_W-1:0] ctrl;
        logic [IRQ_W-1:0]  irq_st;
        logic [IRQ_W-1:0]  irq_msk;
        qec_enc_type       prev;
        logic [31:0]       rdata;
        logic              pready;
    } qec_top_state_type;
endpackage

/* hw/qec_top.sv */
// Quadrature encoder counter with APB register access and interrupt
`timescale 1ns/100ps
//
// Notes on behaviour
// [RULE1] Inputs A, B, index, optional index gate
// [RULE2] Signed count since last zeroing event
// [RULE3] Raw total never cleared after start-up
// [RULE4] Armed index zeroes count, clears arm
// [RULE5] Zero control holds count; host releases it
// [RULE6] Mode bit: quadrature clear, up/down set
// [RULE7] Up/down: A rising counts, B gives direction
// [RULE8] Quadrature counts every edge, four per line
// [RULE9] Long filter needs fifteen stable samples
// [RULE10] Short filter needs three stable samples
// [RULE11] Sampling runs on dedicated sample clock; here the filters sample on the system clock
// [RULE12] Index edge bit: set rising, clear falling
// [RULE13] Gating ignores index unless gate active
// [RULE14] Gate polarity bit: set means active low
// [RULE15] Count and total wrap as 32-bit
//
module qec_top
    import qec_pkg::*;
#(
    parameter bit HAS_GATE = 1'b1
)
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_idx,
    input  wire logic        enc_gate,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    qec_top_state_type st_ff, nxt_st;
    qec_enc_type       flt;
    logic              gate_pin;

    // Four-input variant only; gate pin tied high otherwise, active unless the polarity bit is set
    assign gate_pin = HAS_GATE ? enc_gate : 1'b1;  // [RULE1]

    qec_filter u_fa (.clock(clock), .rstn(rstn), .pin(enc_a),
        .long_sel(st_ff.ctrl[CB_FILT]), .level(flt.a));  // [RULE1]
    qec_filter u_fb (.clock(clock), .rstn(rstn), .pin(enc_b),
        .long_sel(st_ff.ctrl[CB_FILT]), .level(flt.b));
    qec_filter u_fi (.clock(clock), .rstn(rstn), .pin(enc_idx),
        .long_sel(st_ff.ctrl[CB_FILT]), .level(flt.idx));
    qec_filter u_fg (.clock(clock), .rstn(rstn), .pin(gate_pin),
        .long_sel(st_ff.ctrl[CB_FILT]), .level(flt.gate));

    // Step from the filtered phases; +1, -1 or 0
    function automatic logic [1:0] qec_step(input logic mode, input qec_enc_type cur,
                                            input qec_enc_type old);
        logic [1:0] r;
        r = 2'h0;
        if (mode) begin
            if (cur.a && !old.a) begin  // [RULE7]
                r = cur.b ? 2'h1 : 2'h3;
            end
        end else if ((cur.a ^ old.a) || (cur.b ^ old.b)) begin  // [RULE8]
            // Forward when the new A differs from the old B
            if ((cur.a ^ old.a) && (cur.b ^ old.b)) begin
                r = 2'h0;  // Illegal double step is dropped
            end else begin
                r = ((cur.a ^ old.b) != 1'b0) ? 2'h1 : 2'h3;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] qec_apply(input logic [31:0] v, input logic [1:0] s);
        logic [31:0] r;
        r = v;
        if (s == 2'h1) begin
            r = v + 32'h0000_0001;  // [RULE15]
        end else if (s == 2'h3) begin
            r = v - 32'h0000_0001;  // [RULE15]
        end
        return r;
    endfunction

    logic        bus_wr;
    logic        bus_rd;
    logic [1:0]  step;
    logic        idx_edge;
    logic        gate_ok;
    logic        idx_event;

    // Writes land only at the edge where pready is seen high, so never twice
    assign bus_wr = psel && penable && pwrite && st_ff.pready;
    assign bus_rd = psel && !penable && !pwrite;

    always_comb begin
        logic [31:0] wm;
        wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        step = qec_step(st_ff.ctrl[CB_MODE], flt, st_ff.prev);  // [RULE6]
        idx_edge = st_ff.ctrl[CB_IDXRISE] ? (flt.idx && !st_ff.prev.idx)
                                          : (!flt.idx && st_ff.prev.idx);  // [RULE12]
        gate_ok = !st_ff.ctrl[CB_GATE_EN] ||
                  (flt.gate ^ st_ff.ctrl[CB_GATE_INV]);  // [RULE13] [RULE14]
        idx_event = idx_edge && gate_ok && st_ff.ctrl[CB_ARM];
        nxt_st = st_ff;
        nxt_st.prev = flt;
        nxt_st.raw = qec_apply(st_ff.raw, step);  // [RULE3]
        nxt_st.count = qec_apply(st_ff.count, step);  // [RULE2]
        if (idx_event) begin
            nxt_st.count = 32'h0000_0000;  // [RULE4]
            nxt_st.ctrl[CB_ARM] = 1'b0;  // [RULE4]
        end
        if (st_ff.ctrl[CB_ZERO]) begin
            nxt_st.count = 32'h0000_0000;  // [RULE5]
        end
        nxt_st.pready = 1'b0;
        // One wait state: pready rises after the first access edge of a write
        if (psel && penable && pwrite && !st_ff.pready) begin
            nxt_st.pready = 1'b1;
        end
        if (bus_wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    nxt_st.ctrl = (st_ff.ctrl & ~wm[CTRL_W-1:0]) |
                                  (pwdata[CTRL_W-1:0] & wm[CTRL_W-1:0]);
                    if (idx_event) begin
                        nxt_st.ctrl[CB_ARM] = 1'b0;  // Event beats a rearm write
                    end
                end
                ADDR_IRQST: begin
                    nxt_st.irq_st = st_ff.irq_st & ~(pwdata[IRQ_W-1:0] & wm[IRQ_W-1:0]);
                end
                ADDR_IRQMSK: begin
                    nxt_st.irq_msk = (st_ff.irq_msk & ~wm[IRQ_W-1:0]) |
                                     (pwdata[IRQ_W-1:0] & wm[IRQ_W-1:0]);
                end
                default: begin
                end
            endcase
        end
        // Events set after the clear so a same-cycle event survives
        if (idx_event) begin
            nxt_st.irq_st[IB_INDEX] = 1'b1;
        end
        if (step != 2'h0) begin
            nxt_st.irq_st[IB_MOVE] = 1'b1;
        end
        if (bus_rd) begin
            case (paddr)
                ADDR_CTRL:   nxt_st.rdata = {25'h0, st_ff.ctrl};
                ADDR_COUNT:  nxt_st.rdata = st_ff.count;
                ADDR_RAW:    nxt_st.rdata = st_ff.raw;
                ADDR_STATUS: nxt_st.rdata = {28'h0, flt.gate, flt.idx, flt.b, flt.a};
                ADDR_IRQST:  nxt_st.rdata = {30'h0, st_ff.irq_st};
                ADDR_IRQMSK: nxt_st.rdata = {30'h0, st_ff.irq_msk};
                default:     nxt_st.rdata = 32'h0000_0000;
            endcase
            nxt_st.pready = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '{count: 32'h0, raw: 32'h0, ctrl: CTRL_RST, irq_st: '0,
                       irq_msk: '0, prev: '0, rdata: 32'h0, pready: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Reads answer at the first access edge, writes one cycle later
    assign pready  = pwrite ? st_ff.pready : (psel && penable);
    assign prdata  = st_ff.rdata;
    assign pslverr = 1'b0;
    assign irq     = |(st_ff.irq_st & st_ff.irq_msk);

    a_zero_holds: assert property (@(posedge clock) disable iff (!rstn)  // [RULE5]
        st_ff.ctrl[CB_ZERO] && $past(st_ff.ctrl[CB_ZERO]) |-> st_ff.count == 32'h0)
        else $error("count not held at zero");
    a_arm_clears: assert property (@(posedge clock) disable iff (!rstn)  // [RULE4]
        idx_event |=> !st_ff.ctrl[CB_ARM] && st_ff.irq_st[IB_INDEX])
        else $error("arm bit not cleared on index");
    a_index_zero: assert property (@(posedge clock) disable iff (!rstn)  // [RULE4]
        idx_event && !(bus_wr && paddr == ADDR_CTRL) |=> st_ff.count == 32'h0)
        else $error("count not zeroed on index");
    a_raw_tracks: assert property (@(posedge clock) disable iff (!rstn)  // [RULE3]
        step == 2'h1 |=> st_ff.raw == $past(st_ff.raw) + 32'h1)
        else $error("raw total missed a count");
    a_updown_dir: assert property (@(posedge clock) disable iff (!rstn)  // [RULE7]
        st_ff.ctrl[CB_MODE] && flt.a && !st_ff.prev.a && !flt.b |-> step == 2'h3)
        else $error("up/down direction wrong");
    a_updown_quiet: assert property (@(posedge clock) disable iff (!rstn)  // [RULE6]
        st_ff.ctrl[CB_MODE] && !(flt.a && !st_ff.prev.a) |-> step == 2'h0)
        else $error("up/down counted without A rise");
    a_quad_edge: assert property (@(posedge clock) disable iff (!rstn)  // [RULE8]
        !st_ff.ctrl[CB_MODE] && (flt.b != st_ff.prev.b) && (flt.a == st_ff.prev.a)
        |-> step != 2'h0)
        else $error("quadrature edge not counted");
    a_gate_blocks: assert property (@(posedge clock) disable iff (!rstn)  // [RULE13]
        st_ff.ctrl[CB_GATE_EN] && (flt.gate == st_ff.ctrl[CB_GATE_INV]) |-> !idx_event)
        else $error("index passed closed gate");
    a_read_nowait: assert property (@(posedge clock) disable iff (!rstn)
        psel && penable && !pwrite |-> pready)
        else $error("read access not answered at once");
    a_raw_down: assert property (@(posedge clock) disable iff (!rstn)  // [RULE15]
        step == 2'h3 |=> st_ff.raw == $past(st_ff.raw) - 32'h1)
        else $error("raw total missed a down count");
    a_count_up: assert property (@(posedge clock) disable iff (!rstn)  // [RULE2]
        step == 2'h1 && !idx_event && !st_ff.ctrl[CB_ZERO]
        |=> st_ff.count == $past(st_ff.count) + 32'h1)
        else $error("count missed an up count");
    a_edge_rise: assert property (@(posedge clock) disable iff (!rstn)  // [RULE12]
        idx_event && st_ff.ctrl[CB_IDXRISE] |-> flt.idx && !st_ff.prev.idx)
        else $error("index event without rising edge");
    a_edge_fall: assert property (@(posedge clock) disable iff (!rstn)  // [RULE12]
        idx_event && !st_ff.ctrl[CB_IDXRISE] |-> !flt.idx && st_ff.prev.idx)
        else $error("index event without falling edge");
    a_quad_quiet: assert property (@(posedge clock) disable iff (!rstn)  // [RULE8]
        !st_ff.ctrl[CB_MODE] && (flt.a == st_ff.prev.a) && (flt.b == st_ff.prev.b)
        |-> step == 2'h0)
        else $error("quadrature counted without an edge");
endmodule

/* test/qec_enc_model.sv */
// Behavioural incremental encoder with index and gate outputs
`timescale 1ns/100ps
module qec_enc_model (
    input  wire logic clock,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_idx,
    output logic      enc_gate
);
    int ph = 0;
    initial begin
        {enc_a, enc_b, enc_idx, enc_gate} = 4'h0;
    end
    task automatic put(input logic a, input logic b, input int n);
        @(posedge clock);
        enc_a <= a;
        enc_b <= b;
        repeat (n - 1) @(posedge clock);
    endtask
    // Gray order 00,10,11,01 so that A leads B going forward
    task automatic step(input int dir, input int n);
        ph = (ph + dir + 4) % 4;
        put(ph == 1 || ph == 2, ph >= 2, n);
    endtask
    task automatic pin_gate(input logic v, input int n);
        @(posedge clock);
        enc_gate <= v;
        repeat (n - 1) @(posedge clock);
    endtask
    task automatic pin_idx(input logic v, input int n);
        @(posedge clock);
        enc_idx <= v;
        repeat (n - 1) @(posedge clock);
    endtask
endmodule

/* test/test_qec_top.sv */
// Self-checking bench for the quadrature encoder counter
`timescale 1ns/100ps
module test_qec_top;
    import qec_pkg::*;
    logic        clock;
    logic        rstn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        irq;
    logic        enc_a;
    logic        enc_b;
    logic        enc_idx;
    logic        enc_gate;
    logic [31:0] rd;
    int          err_count = 0;
    int          checks_done = 0;

    qec_top dut (.clock(clock), .rstn(rstn), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx),
        .enc_gate(enc_gate), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(),
        .irq(irq));
    qec_enc_model enc (.clock(clock), .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx),
        .enc_gate(enc_gate));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Entered just after a rising edge; leaves just after one
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock iff pready === 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic counts(input logic [31:0] c, input logic [31:0] r);
        repeat (20) @(posedge clock);
        rchk("count", ADDR_COUNT, c);
        rchk("raw", ADDR_RAW, r);
    endtask
    // Up/down pulses on A with B held at the given level
    task automatic pulse(input logic b, input int k);
        enc.put(1'b0, b, 6);
        repeat (k) begin
            enc.put(1'b1, b, 6);
            enc.put(1'b0, b, 6);
        end
    endtask
    task automatic t_reset;
        rchk("ctrl", ADDR_CTRL, 32'h2);
        counts(32'h0, 32'h0);
        rchk("unmapped", 8'h18, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    task automatic t_quad;
        enc.put(1'b1, 1'b0, 10);
        enc.put(1'b0, 1'b0, 30);
        counts(32'h0, 32'h0);
        rchk("irqst", ADDR_IRQST, 32'h0);
        repeat (8) enc.step(1, 20);
        repeat (12) enc.step(-1, 20);
        counts(32'hFFFFFFFC, 32'hFFFFFFFC);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_IRQST, 32'h3);
        enc.put(1'b1, 1'b0, 2);
        enc.put(1'b0, 1'b0, 10);
        rchk("irqst", ADDR_IRQST, 32'h0);
        repeat (4) enc.step(1, 5);
        counts(32'h0, 32'h0);
    endtask
    task automatic t_updown;
        apb(1'b1, ADDR_CTRL, 32'h1);
        pulse(1'b1, 3);
        pulse(1'b0, 2);
        counts(32'h1, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h41);
        pulse(1'b1, 2);
        counts(32'h0, 32'h3);
        apb(1'b1, ADDR_CTRL, 32'h1);
        pulse(1'b1, 1);
        counts(32'h1, 32'h4);
    endtask
    task automatic t_index;
        apb(1'b1, ADDR_IRQST, 32'h3);
        apb(1'b1, ADDR_IRQMSK, 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h2D);
        enc.pin_idx(1'b1, 6);
        enc.pin_idx(1'b0, 10);
        rchk("ctrl", ADDR_CTRL, 32'h2D);
        counts(32'h1, 32'h4);
        apb(1'b1, ADDR_CTRL, 32'h3D);
        enc.pin_idx(1'b1, 6);
        enc.pin_idx(1'b0, 10);
        rchk("ctrl", ADDR_CTRL, 32'h1D);
        counts(32'h0, 32'h4);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, ADDR_IRQST, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        rchk("irqst", ADDR_IRQST, 32'h0);
        pulse(1'b1, 1);
        rchk("irqst", ADDR_IRQST, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h21);
        enc.pin_idx(1'b1, 10);
        rchk("ctrl", ADDR_CTRL, 32'h21);
        enc.pin_idx(1'b0, 10);
        rchk("ctrl", ADDR_CTRL, 32'h1);
        counts(32'h0, 32'h5);
        enc.pin_gate(1'b1, 10);
        rchk("status", ADDR_STATUS, 32'hA);
        apb(1'b1, ADDR_CTRL, 32'h3D);
        enc.pin_idx(1'b1, 6);
        enc.pin_idx(1'b0, 10);
        rchk("ctrl", ADDR_CTRL, 32'h3D);
        apb(1'b1, ADDR_CTRL, 32'h2D);
        enc.pin_idx(1'b1, 6);
        enc.pin_idx(1'b0, 10);
        rchk("ctrl", ADDR_CTRL, 32'hD);
        rchk("irqst", ADDR_IRQST, 32'h3);
    endtask
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(20 * 20000);
        err_count++;
        wrap_up();
    end
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_quad();
        t_updown();
        t_index();
        wrap_up();
    end
endmodule
